/* File: core/scs_consts.vh */
// Constants for the synchronous control cancel/start block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// ----------------------------------------------------------------------
// Axis layout
// ----------------------------------------------------------------------
`define SCS_AXES            8
`define SCS_VIRT_FIRST      6
// Host relay numbers of axis 1; later axes follow consecutively
`define SCS_CANCEL_REQ_RELAY  16'h0158
`define SCS_CANCEL_NOT_RELAY  16'h0158
`define SCS_CLUTCH_REQ_RELAY  16'h0160
`define SCS_CLUTCH_NOT_RELAY  16'h0160

// ----------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------
`define SCS_OFF_CANCEL_REQ  12'h000
`define SCS_OFF_CLUTCH_REQ  12'h004
`define SCS_OFF_GEAR_REQ    12'h008
`define SCS_OFF_SLIP_CFG    12'h00C
`define SCS_OFF_MCYCLE      12'h010
`define SCS_OFF_STATUS      12'h014
`define SCS_OFF_COND        12'h018
`define SCS_OFF_STOP_CNT    12'h01C
`define SCS_OFF_PHASE0      12'h020
`define SCS_OFF_PHASE7      12'h03C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCS_ST_CANCEL_LSB   0
`define SCS_ST_CLUTCH_LSB   8
`define SCS_ST_GEAR_LSB     16
`define SCS_ST_RUN_LSB      24
`define SCS_CD_BUSY_LSB     0
`define SCS_CD_STOP_LSB     8
`define SCS_CD_ERR_LSB      16
`define SCS_CD_WAIT_LSB     24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCS_RST_CANCEL_REQ  8'h00
`define SCS_RST_CLUTCH_REQ  8'h00
`define SCS_RST_GEAR_REQ    8'h00
`define SCS_RST_SLIP_CFG    8'h00
`define SCS_RST_MCYCLE      32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCS_CLK_NS          100
`define SCS_SLIP_NS         1000
`define SCS_SLIP_CYC        ((`SCS_SLIP_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_SLIP_W          4

`endif

/* File: core/scs_axis.v */
// Per-axis cancel/start state machine
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"

module scs_axis
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        cancel_req,
    input  wire        clutch_req,
    input  wire        gear_req,
    input  wire        slip_en,
    input  wire        slave_busy,
    input  wire        slave_stop_req,
    input  wire        slave_err,
    input  wire        master_moving,
    input  wire [31:0] phase_now,
    output reg         cancel_note_ff,
    output reg         clutch_note_ff,
    output reg         gear_note_ff,
    output reg         slave_run_ff,
    output reg         stop_now_ff,
    output reg  [31:0] phase_ff
);

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    localparam [1:0] ST_CANCEL = 2'b01;
    localparam [1:0] ST_SYNC   = 2'b10;

    reg  [1:0]               state_ff;
    reg  [`SCS_SLIP_W-1:0]   slip_cnt_ff;
    reg                      slip_act_ff;
    wire                     start_ok;
    wire [`SCS_SLIP_W-1:0]   slip_load;
    wire [31:0]              slip_full;

    assign start_ok  = !slave_busy && !slave_stop_req && !slave_err;
    assign slip_full = `SCS_SLIP_CYC;
    assign slip_load = slip_full[`SCS_SLIP_W-1:0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff       <= ST_CANCEL;
            cancel_note_ff <= 1'b1;
            clutch_note_ff <= 1'b0;
            gear_note_ff   <= 1'b0;
            slave_run_ff   <= 1'b0;
            stop_now_ff    <= 1'b0;
            phase_ff       <= 32'h0000_0000;
            slip_cnt_ff    <= {`SCS_SLIP_W{1'b0}};
            slip_act_ff    <= 1'b0;
        end
        else
        begin
            stop_now_ff <= 1'b0;
            case (state_ff)
                ST_CANCEL:
                begin
                    slave_run_ff <= 1'b0;
                    // Stay canceled with the note on until start is legal
                    if (!cancel_req && start_ok)
                    begin
                        state_ff       <= ST_SYNC;
                        cancel_note_ff <= 1'b0;
                        phase_ff       <= phase_now;
                        // Level trigger sampled at start: direct engage
                        clutch_note_ff <= clutch_req;
                        slave_run_ff   <= clutch_req;
                        slip_act_ff    <= 1'b0;
                    end
                end
                ST_SYNC:
                begin
                    if (cancel_req)
                    begin
                        state_ff       <= ST_CANCEL;
                        cancel_note_ff <= 1'b1;
                        clutch_note_ff <= 1'b0;
                        gear_note_ff   <= 1'b0;
                        slave_run_ff   <= 1'b0;
                        slip_act_ff    <= 1'b0;
                        // Slave cannot follow a moving master any more
                        stop_now_ff    <= master_moving;
                    end
                    else
                    begin
                        gear_note_ff <= gear_req;
                        if (!clutch_req)
                        begin
                            clutch_note_ff <= 1'b0;
                            slave_run_ff   <= 1'b0;
                            slip_act_ff    <= 1'b0;
                        end
                        else if (!clutch_note_ff)
                        begin
                            // Later engage follows the slip choice
                            if (!slip_en || (slip_act_ff && slip_cnt_ff == 4'h1))
                            begin
                                clutch_note_ff <= 1'b1;
                                slave_run_ff   <= 1'b1;
                                slip_act_ff    <= 1'b0;
                            end
                            else if (!slip_act_ff)
                            begin
                                slip_act_ff <= 1'b1;
                                slip_cnt_ff <= slip_load;
                            end
                            else
                            begin
                                slip_cnt_ff <= slip_cnt_ff - 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    state_ff       <= ST_CANCEL;
                    cancel_note_ff <= 1'b1;
                end
            endcase
        end
    end

endmodule // scs_axis
`default_nettype wire

/* File: core/scs_top.v */
// Synchronous control cancel/start block with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"

// Behaviour
// - Canceling while master moves stops slave axes immediately.
// - Cancel clears gear-change and clutch connection notifications.
// - Start only with slaves stopped, no stop request, no error.
// - Conditions unmet: stay canceled, keep in-progress note on.
// - Cancel request low: start automatically once conditions hold.
// - Start phase is master position modulo master cycle.
// - Clutch request off makes clutch notification go off.
// - Cancel request on makes in-progress notification go on.
// - Cancel request off lets in-progress notification drop.
// - Clutch request on engages clutch, notification on, slave moves.
// - Clutch request on at start: engage directly, ignore slip.
// - Clutch request off at start: engage later by slip method; the code engages directly where slip_en is clear.
// - Clutch engaged at start: slave moves as note drops.
// - Clutch not engaged at start: slave waits for clutch request.
// - Eight axes, last two virtual, each with own bits.
module scs_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    input  wire [7:0]  slave_busy,
    input  wire [7:0]  slave_stop_req,
    input  wire [7:0]  slave_err,
    input  wire        master_moving,
    input  wire [31:0] master_pos,
    output wire [7:0]  cancel_note,
    output wire [7:0]  clutch_note,
    output wire [7:0]  gear_note,
    output wire [7:0]  slave_run,
    output wire [7:0]  slave_stop_now
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [7:0]   cancel_req_ff;
    reg  [7:0]   clutch_req_ff;
    reg  [7:0]   gear_req_ff;
    reg  [7:0]   slip_cfg_ff;
    reg  [31:0]  mcycle_ff;
    reg  [15:0]  stop_cnt_ff;
    reg  [31:0]  nxt_prdata;
    reg          nxt_pslverr;
    wire [31:0]  phase_now;
    wire [255:0] phase_all;
    wire         acc;
    wire         wr_ok;
    wire [2:0]   phase_idx;
    wire         phase_hit;
    wire [7:0]   start_block;
    reg  [7:0]   start_wait_ff;
    wire         stop_clr;
    reg  [15:0]  nxt_stop_cnt;

    // ------------------------------------------------------------------
    // Phase source
    // ------------------------------------------------------------------
    // A zero cycle would divide by zero; the raw position is used then
    assign phase_now = (mcycle_ff == 32'h0000_0000) ? master_pos
                                                    : (master_pos % mcycle_ff);

    // ------------------------------------------------------------------
    // Axis instances
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SCS_AXES; g = g + 1)
        begin : g_axis
            // Bits of axis g sit at bit g of each word, consecutively
            scs_axis u_axis
            (
                .pclk           (pclk),
                .presetn        (presetn),
                .cancel_req     (cancel_req_ff[g]),
                .clutch_req     (clutch_req_ff[g]),
                .gear_req       (gear_req_ff[g]),
                .slip_en        (slip_cfg_ff[g]),
                .slave_busy     (slave_busy[g]),
                .slave_stop_req (slave_stop_req[g]),
                .slave_err      (slave_err[g]),
                .master_moving  (master_moving),
                .phase_now      (phase_now),
                .cancel_note_ff (cancel_note[g]),
                .clutch_note_ff (clutch_note[g]),
                .gear_note_ff   (gear_note[g]),
                .slave_run_ff   (slave_run[g]),
                .stop_now_ff    (slave_stop_now[g]),
                .phase_ff       (phase_all[g*32 +: 32])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    // One wait state keeps read data registered
    assign acc       = psel && penable && !pready_ff;
    assign wr_ok     = acc && pwrite && !nxt_pslverr;
    assign phase_hit = (paddr >= `SCS_OFF_PHASE0) && (paddr <= `SCS_OFF_PHASE7)
                       && (paddr[1:0] == 2'b00);
    assign phase_idx = paddr[4:2];

    // Unaligned and unmapped addresses land in the error default
    always @*
    begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (paddr)
            `SCS_OFF_CANCEL_REQ:
            begin
                nxt_prdata = {24'h00_0000, cancel_req_ff};
            end
            `SCS_OFF_CLUTCH_REQ:
            begin
                nxt_prdata = {24'h00_0000, clutch_req_ff};
            end
            `SCS_OFF_GEAR_REQ:
            begin
                nxt_prdata = {24'h00_0000, gear_req_ff};
            end
            `SCS_OFF_SLIP_CFG:
            begin
                nxt_prdata = {24'h00_0000, slip_cfg_ff};
            end
            `SCS_OFF_MCYCLE:
            begin
                nxt_prdata = mcycle_ff;
            end
            `SCS_OFF_STATUS:
            begin
                nxt_prdata[`SCS_ST_CANCEL_LSB +: 8] = cancel_note;
                nxt_prdata[`SCS_ST_CLUTCH_LSB +: 8] = clutch_note;
                nxt_prdata[`SCS_ST_GEAR_LSB +: 8]   = gear_note;
                nxt_prdata[`SCS_ST_RUN_LSB +: 8]    = slave_run;
                nxt_pslverr = pwrite;
            end
            `SCS_OFF_COND:
            begin
                nxt_prdata[`SCS_CD_BUSY_LSB +: 8] = slave_busy;
                nxt_prdata[`SCS_CD_STOP_LSB +: 8] = slave_stop_req;
                nxt_prdata[`SCS_CD_ERR_LSB +: 8]  = slave_err;
                nxt_prdata[`SCS_CD_WAIT_LSB +: 8] = start_wait_ff;
                nxt_pslverr = pwrite;
            end
            `SCS_OFF_STOP_CNT:
            begin
                nxt_prdata  = {16'h0000, stop_cnt_ff};
            end
            default:
            begin
                if (phase_hit)
                begin
                    nxt_prdata  = phase_all[phase_idx*32 +: 32];
                    nxt_pslverr = pwrite;
                end
                else
                begin
                    nxt_pslverr = 1'b1;
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= acc;
            pslverr_ff <= acc && nxt_pslverr;
            if (acc && !pwrite)
            begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    // Host should drop clutch bits before setting cancel bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cancel_req_ff <= `SCS_RST_CANCEL_REQ;
            clutch_req_ff <= `SCS_RST_CLUTCH_REQ;
            gear_req_ff   <= `SCS_RST_GEAR_REQ;
            slip_cfg_ff   <= `SCS_RST_SLIP_CFG;
            mcycle_ff     <= `SCS_RST_MCYCLE;
        end
        else if (wr_ok)
        begin
            case (paddr)
                `SCS_OFF_CANCEL_REQ:
                begin
                    cancel_req_ff <= pwdata[7:0];
                end
                `SCS_OFF_CLUTCH_REQ:
                begin
                    clutch_req_ff <= pwdata[7:0];
                end
                `SCS_OFF_GEAR_REQ:
                begin
                    gear_req_ff <= pwdata[7:0];
                end
                `SCS_OFF_SLIP_CFG:
                begin
                    slip_cfg_ff <= pwdata[7:0];
                end
                `SCS_OFF_MCYCLE:
                begin
                    mcycle_ff <= pwdata;
                end
                default:
                begin
                    mcycle_ff <= mcycle_ff;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Start-wait status
    // ------------------------------------------------------------------
    // Axes held canceled by unmet start conditions alone
    // Lets the host tell a blocked start from a pending cancel
    // Registered, so it lags the conditions by one cycle
    assign start_block = slave_busy | slave_stop_req | slave_err;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_wait_ff <= 8'h00;
        end
        else
        begin
            start_wait_ff <= cancel_note & ~cancel_req_ff
                             & start_block;
        end
    end

    // ------------------------------------------------------------------
    // Immediate stop counter
    // ------------------------------------------------------------------
    // Counts cycles with a stop on any axis, once per cycle however many axes stop; a write of any value clears it
    // Saturates, so a wrap cannot pass for a low count
    assign stop_clr = wr_ok && (paddr == `SCS_OFF_STOP_CNT);

    always @*
    begin
        nxt_stop_cnt = stop_cnt_ff;
        if (|slave_stop_now)
        begin
            // An event in the cycle of a clear wins
            if (stop_cnt_ff != 16'hFFFF)
            begin
                nxt_stop_cnt = stop_cnt_ff + 16'h0001;
            end
        end
        else if (stop_clr)
        begin
            nxt_stop_cnt = 16'h0000;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_cnt_ff <= 16'h0000;
        end
        else
        begin
            stop_cnt_ff <= nxt_stop_cnt;
        end
    end

endmodule // scs_top
`default_nettype wire

/* File: testbench/scs_top_sva.sv */
// Port checker for the synchronous control cancel/start block
`timescale 1ns/1ps
`default_nettype none
module scs_top_sva
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready_ff,
    input wire logic       pslverr_ff,
    input wire logic [7:0] slave_busy,
    input wire logic [7:0] slave_stop_req,
    input wire logic [7:0] slave_err,
    input wire logic       master_moving,
    input wire logic [7:0] cancel_note,
    input wire logic [7:0] clutch_note,
    input wire logic [7:0] gear_note,
    input wire logic [7:0] slave_run,
    input wire logic [7:0] slave_stop_now
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready_ff;
    endsequence
    sequence s_cancel_rise;
        (cancel_note & ~$past(cancel_note)) != 8'h00;
    endsequence

    chk_apb_answer: assert property (s_access |=> pready_ff)
        else $error("apb access not answered one cycle later");
    chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
        else $error("pready held longer than one cycle");
    chk_err_ready: assert property (pslverr_ff |-> pready_ff)
        else $error("pslverr without pready");
    chk_stop_cancel: assert property
        (s_cancel_rise ##0 $past(master_moving) |-> ##[0:1] (slave_stop_now != 8'h00))
        else $error("no slave stop on cancel while master moves");
    chk_stop_pulse: assert property ((slave_stop_now & $past(slave_stop_now)) == 8'h00)
        else $error("slave stop longer than one cycle");
    chk_cancel_clears: assert property ((cancel_note & (clutch_note | gear_note)) == 8'h00)
        else $error("clutch or gear note set while canceled");
    // Registered decision, so the cause sits one cycle back
    chk_start_conds: assert property
        ((~cancel_note & $past(cancel_note)
          & ($past(slave_busy) | $past(slave_stop_req) | $past(slave_err))) == 8'h00)
        else $error("start while slave not ready");
    chk_run_clutch: assert property ((slave_run & ~clutch_note) == 8'h00)
        else $error("slave runs without clutch");
endmodule // scs_top_sva

bind scs_top scs_top_sva scs_top_sva_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .slave_busy(slave_busy),
    .slave_stop_req(slave_stop_req), .slave_err(slave_err),
    .master_moving(master_moving), .cancel_note(cancel_note),
    .clutch_note(clutch_note), .gear_note(gear_note), .slave_run(slave_run),
    .slave_stop_now(slave_stop_now)
);
`default_nettype wire

/* File: testbench/scs_host.sv */
// Host model: APB master playing the user program
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"
module scs_host
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata_ff,
    input  wire logic        pready_ff,
    input  wire logic        pslverr_ff
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    logic [7:0]  cancel_sh = 8'h00;
    logic [7:0]  clutch_sh = 8'h00;
    logic        hang = 1'b0;
    logic        er;
    logic [31:0] rd;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready_ff !== 1'b1 && n < 50);
        // Bench watches this flag and closes the run
        if (n >= 50)
            hang = 1'b1;
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Shadows keep untouched axes as they were
    task automatic clutch(input logic [7:0] m, input logic on);
        clutch_sh = on ? (clutch_sh | m) : (clutch_sh & ~m);
        xfer(1'b1, `SCS_OFF_CLUTCH_REQ, {24'h00_0000, clutch_sh});
    endtask

    task automatic cancel(input logic [7:0] m, input logic on);
        cancel_sh = on ? (cancel_sh | m) : (cancel_sh & ~m);
        xfer(1'b1, `SCS_OFF_CANCEL_REQ, {24'h00_0000, cancel_sh});
    endtask
endmodule // scs_host
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the synchronous control cancel/start block
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, master_pos, rnd, cyc;
    logic [7:0]  slave_busy, slave_stop_req, slave_err, cancel_note, clutch_note;
    logic [7:0]  gear_note, slave_run, slave_stop_now, m, s, bm;
    logic        master_moving;
    logic [15:0] stops;
    int          bad_count, checks_done, n;

    scs_top scs_top_i (.*);
    scs_host scs_host_i (.*);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (scs_host_i.hang === 1'b1)
        begin
            bad_count++;
            test_done;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [31:0] exp_phase(input logic [31:0] p, input logic [31:0] c);
        return (c == 32'h0000_0000) ? p : p % c;
    endfunction

    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        scs_host_i.xfer(1'b0, a, 32'h0000_0000);
        cmp32("prdata", e, scs_host_i.rd);
        cmp8("pslverr", {7'h00, ee}, {7'h00, scs_host_i.er});
    endtask

    task automatic settle;
        @(posedge pclk);
        #1;
    endtask

    task automatic test_done;
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        slave_busy = 8'h00;
        slave_stop_req = 8'h00;
        slave_err = 8'h00;
        master_moving = 1'b0;
        master_pos = 32'h0000_0000;
        rnd = 32'h0000_4464;
        bad_count = 0;
        checks_done = 0;
        stops = 16'h0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        cmp8("cancel_note", 8'hFF, cancel_note);
        settle;
        cmp8("cancel_note", 8'h00, cancel_note);
        rd_chk(`SCS_OFF_CLUTCH_REQ, 32'h0000_0000, 1'b0);
        rd_chk(`SCS_OFF_MCYCLE, 32'h0000_0000, 1'b0);
        rd_chk(12'h040, 32'h0000_0000, 1'b1);
        scs_host_i.xfer(1'b1, `SCS_OFF_STATUS, 32'hFFFF_FFFF);
        cmp8("write_err", 8'h01, {7'h00, scs_host_i.er});
        scs_host_i.xfer(1'b1, `SCS_OFF_GEAR_REQ, 32'h0000_00FF);
        scs_host_i.clutch(8'hFF, 1'b1);
        settle;
        cmp8("slave_run", 8'hFF, slave_run);
        cmp8("gear_note", 8'hFF, gear_note);
        for (int k = 0; k < 12; k++)
        begin
            rnd = lfsr(rnd);
            cyc = (k == 0) ? 32'h0000_0000 : {16'h0000, rnd[15:0]};
            m = (k == 0) ? 8'hFF : (rnd[23:16] | 8'h01);
            s = rnd[31:24];
            bm = 8'h01 << rnd[2:0];
            rnd = lfsr(rnd);
            @(posedge pclk);
            master_pos <= rnd;
            master_moving <= rnd[0];
            scs_host_i.xfer(1'b1, `SCS_OFF_MCYCLE, cyc);
            scs_host_i.xfer(1'b1, `SCS_OFF_SLIP_CFG, {24'h00_0000, s});
            scs_host_i.clutch(m, 1'b0);
            settle;
            cmp8("clutch_note", ~m, clutch_note);
            scs_host_i.cancel(m, 1'b1);
            settle;
            stops = stops + {15'h0000, master_moving};
            cmp8("cancel_note", m, cancel_note);
            cmp8("gear_note", ~m, gear_note);
            @(posedge pclk);
            // One axis held back by a rotating kind of blocker
            slave_busy <= (k % 3 == 0) ? bm : 8'h00;
            slave_stop_req <= (k % 3 == 1) ? bm : 8'h00;
            slave_err <= (k % 3 == 2) ? bm : 8'h00;
            if (k[0])
                scs_host_i.clutch(m, 1'b1);
            scs_host_i.cancel(m, 1'b0);
            settle;
            cmp8("cancel_note", m & bm, cancel_note);
            cmp8("clutch_note", k[0] ? ~(m & bm) : ~m, clutch_note);
            cmp8("slave_run", k[0] ? ~(m & bm) : ~m, slave_run);
            rd_chk(`SCS_OFF_COND, {m & bm, slave_err, slave_stop_req, slave_busy}, 1'b0);
            @(posedge pclk);
            slave_busy <= 8'h00;
            slave_stop_req <= 8'h00;
            slave_err <= 8'h00;
            settle;
            cmp8("cancel_note", 8'h00, cancel_note);
            if (!k[0])
            begin
                scs_host_i.clutch(m, 1'b1);
                settle;
                cmp8("clutch_note", ~(m & s), clutch_note);
            end
            n = 0;
            while (clutch_note !== 8'hFF && n < 15)
            begin
                settle;
                n++;
            end
            cmp8("clutch_note", 8'hFF, clutch_note);
            cmp8("slave_run", 8'hFF, slave_run);
            for (int a = 0; a < 8; a++)
                if (m[a])
                    rd_chk(`SCS_OFF_PHASE0 + 12'(4 * a), exp_phase(master_pos, cyc), 1'b0);
            rd_chk(`SCS_OFF_STOP_CNT, {16'h0000, stops}, 1'b0);
        end
        scs_host_i.xfer(1'b1, `SCS_OFF_STOP_CNT, 32'h0000_0000);
        rd_chk(`SCS_OFF_STOP_CNT, 32'h0000_0000, 1'b0);
        rd_chk(`SCS_OFF_STATUS, 32'hFFFF_FF00, 1'b0);
        test_done;
    end
endmodule // tb
`default_nettype wire
